// ### logic/gxp_expander.v
`timescale 1ns/10ps
`include "gxp_defs.vh"

module gxp_expander
(
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe_o,
    input  wire [2:0] addr_sel_i,
    input  wire [7:0] port_pin_i,
    output reg  [7:0] port_pin_o,
    output reg  [7:0] port_pin_oe_o,
    output reg  [7:0] port_pullup_o,
    output reg        int_n_o,
    output reg        int_oe_o
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_AACK = 3'h2;
    localparam [2:0] ST_WR   = 3'h3;
    localparam [2:0] ST_WACK = 3'h4;
    localparam [2:0] ST_RD   = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    // Synchronisers: the first stage feeds only the second.
    reg [1:0]  scl_s_q, sda_s_q;
    reg [7:0]  pin_s1_q, pin_s2_q;
    reg [2:0]  asel_s1_q, asel_s2_q;
    reg        scl_d1_q, sda_d1_q;
    reg [2:0]  state_q;
    reg [3:0]  bit_q;
    reg [7:0]  shift_q;
    reg        first_q;
    reg        acked_q;
    reg [1:0]  cmd_q;
    reg [7:0]  input_q, output_q, polar_q, dir_q;

    wire scl_w = scl_s_q[1];
    wire sda_w = sda_s_q[1];
    wire scl_rise = scl_w & ~scl_d1_q;
    wire scl_fall = ~scl_w & scl_d1_q;
    wire start_w  = scl_w & scl_d1_q & sda_d1_q & ~sda_w;
    wire stop_w   = scl_w & scl_d1_q & ~sda_d1_q & sda_w;

    // Register readback; input reads apply polarity inversion.
    function [7:0] rd_mux;
        input [1:0] sel;
        begin
            case (sel)
                `GXP_REG_INPUT:  rd_mux = pin_s2_q ^ polar_q;
                `GXP_REG_OUTPUT: rd_mux = output_q;
                `GXP_REG_POLAR:  rd_mux = polar_q;
                default:         rd_mux = dir_q;
            endcase
        end
    endfunction

    // Byte that a read loads; an input read reports the pins as they stand now, while the same
    // edge snapshots them into the held input so the interrupt compares against those pins, before polarity inversion.
    wire [7:0] rd_byte_w = rd_mux(cmd_q);

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_s_q   <= 2'h3;
            sda_s_q   <= 2'h3;
            scl_d1_q  <= 1'b1;
            sda_d1_q  <= 1'b1;
            pin_s1_q  <= 8'h00;
            pin_s2_q  <= 8'h00;
            asel_s1_q <= 3'h0;
            asel_s2_q <= 3'h0;
        end
        else
        begin
            scl_s_q   <= {scl_s_q[0], scl_i};
            sda_s_q   <= {sda_s_q[0], sda_i};
            scl_d1_q  <= scl_w;
            sda_d1_q  <= sda_w;
            pin_s1_q  <= port_pin_i;
            pin_s2_q  <= pin_s1_q;
            asel_s1_q <= addr_sel_i;
            asel_s2_q <= asel_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave. Data is sampled on SCL rise and driven after SCL fall.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q  <= ST_IDLE;
            bit_q    <= 4'h0;
            shift_q  <= 8'h00;
            first_q  <= 1'b0;
            acked_q  <= 1'b0;
            cmd_q    <= `GXP_REG_INPUT;
            output_q <= `GXP_RST_OUTPUT;
            polar_q  <= `GXP_RST_POLAR;
            dir_q    <= `GXP_RST_DIR;
            input_q  <= 8'h00;
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else if (start_w)
        begin
            state_q  <= ST_ADDR;
            bit_q    <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop_w)
        begin
            state_q  <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_ADDR, ST_WR:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_w};
                        bit_q   <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8)
                    begin
                        bit_q <= 4'h0;
                        if (state_q == ST_ADDR)
                        begin
                            if (shift_q[7:1] == {`GXP_ADDR_FIXED, asel_s2_q})
                            begin
                                sda_oe_o <= 1'b1;
                                state_q  <= ST_AACK;
                            end
                            else
                                state_q <= ST_IDLE;
                        end
                        else
                        begin
                            sda_oe_o <= 1'b1;
                            state_q  <= ST_WACK;
                            if (first_q)
                                cmd_q <= shift_q[1:0];
                            else
                            begin
                                case (cmd_q)
                                    `GXP_REG_OUTPUT: output_q <= shift_q;
                                    `GXP_REG_POLAR:  polar_q  <= shift_q;
                                    `GXP_REG_DIR:    dir_q    <= shift_q;
                                    default:         ;
                                endcase
                            end
                            first_q <= 1'b0;
                        end
                    end
                end
                ST_AACK:
                    if (scl_fall)
                    begin
                        if (shift_q[0])
                        begin
                            state_q  <= ST_RD;
                            shift_q  <= rd_byte_w;
                            sda_o    <= 1'b0;
                            sda_oe_o <= ~rd_byte_w[7];
                            bit_q    <= 4'h1;
                            if (cmd_q == `GXP_REG_INPUT)
                                input_q <= pin_s2_q;
                        end
                        else
                        begin
                            sda_oe_o <= 1'b0;
                            first_q  <= 1'b1;
                            state_q  <= ST_WR;
                        end
                    end
                ST_WACK:
                    if (scl_fall)
                    begin
                        sda_oe_o <= 1'b0;
                        state_q  <= ST_WR;
                    end
                ST_RD:
                    if (scl_fall)
                    begin
                        if (bit_q == 4'h8)
                        begin
                            sda_oe_o <= 1'b0;
                            state_q  <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe_o <= ~shift_q[7 - bit_q[2:0]];   // Open drain: drive only zeros.
                            bit_q    <= bit_q + 4'h1;
                        end
                    end
                ST_RACK:
                begin
                    if (scl_rise)
                        acked_q <= ~sda_w;
                    if (scl_fall)
                    begin
                        if (acked_q)
                        begin
                            state_q  <= ST_RD;
                            shift_q  <= rd_byte_w;
                            sda_oe_o <= ~rd_byte_w[7];
                            bit_q    <= 4'h1;
                            if (cmd_q == `GXP_REG_INPUT)
                                input_q <= pin_s2_q;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive and interrupt. A pin whose direction bit is one is an input.
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            port_pin_o    <= `GXP_RST_OUTPUT;
            port_pin_oe_o <= 8'h00;
            port_pullup_o <= 8'hFF;
            int_n_o       <= 1'b0;
            int_oe_o      <= 1'b0;
        end
        else
        begin
            port_pin_o    <= output_q;
            port_pin_oe_o <= ~dir_q;
            port_pullup_o <= dir_q;
            int_n_o       <= 1'b0;
            int_oe_o      <= |((pin_s2_q ^ input_q) & dir_q);
        end
    end

endmodule // gxp_expander

// ### inc/gxp_defs.vh
`ifndef GXP_DEFS_VH
`define GXP_DEFS_VH
`define GXP_ADDR_FIXED   4'h4
`define GXP_REG_INPUT    2'h0
`define GXP_REG_OUTPUT   2'h1
`define GXP_REG_POLAR    2'h2
`define GXP_REG_DIR      2'h3
`define GXP_RST_OUTPUT   8'hFF
`define GXP_RST_POLAR    8'h00
`define GXP_RST_DIR      8'hFF
`endif

// ### testbench/gxp_expander_props.sv
`timescale 1ns/10ps
module gxp_expander_props
(
    input wire       clk_i,
    input wire       rst_n_i,
    input wire       scl_i,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire [2:0] addr_sel_i,
    input wire [7:0] port_pin_i,
    input wire [7:0] port_pin_o,
    input wire [7:0] port_pin_oe_o,
    input wire [7:0] port_pullup_o,
    input wire       int_n_o,
    input wire       int_oe_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
property p_pull_dir; port_pullup_o == ~port_pin_oe_o; endproperty
a_pull_dir: assert property (p_pull_dir) else $error("pull-up on a driven pin");
property p_rst_vals;
    $rose(rst_n_i) |-> port_pullup_o == 8'hFF && port_pin_o == 8'hFF && !sda_oe_o && !int_oe_o;
endproperty
a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");
property p_sda_lvl; sda_o == 1'b0; endproperty
a_sda_lvl: assert property (p_sda_lvl) else $error("data line driven high");
property p_int_lvl; int_n_o == 1'b0; endproperty
a_int_lvl: assert property (p_int_lvl) else $error("interrupt driven high");
property p_sda_scl; $changed(sda_oe_o) |-> !scl_i; endproperty
a_sda_scl: assert property (p_sda_scl) else $error("data moved while clock high");
// The output flop follows the register one cycle later, so the clock seen one edge back matters.
property p_out_scl; $changed(port_pin_o) |-> !$past(scl_i); endproperty
a_out_scl: assert property (p_out_scl) else $error("output latch moved mid bit");
property p_dir_scl; $changed(port_pin_oe_o) |-> !$past(scl_i); endproperty
a_dir_scl: assert property (p_dir_scl) else $error("direction moved mid bit");
// With pins quiet the held input already matches, so the flag has no cause to rise.
property p_int_quiet; (!int_oe_o && $stable(port_pin_i)) [*6] |=> !int_oe_o; endproperty
a_int_quiet: assert property (p_int_quiet) else $error("interrupt without pin change");
endmodule // gxp_expander_props
bind gxp_expander gxp_expander_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
    .port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .port_pullup_o(port_pullup_o), .int_n_o(int_n_o), .int_oe_o(int_oe_o));

// ### testbench/gxp_i2c_master.sv
`timescale 1ns/10ps
module gxp_i2c_master
(
    input  wire  clk_i,
    input  wire  sda_i,
    output logic scl_o = 1'b1,
    output logic sda_low_o = 1'b0
);
// The data line changes one cycle after the clock falls so no false start is seen.
task automatic bit_x(input logic b, output logic r);
    @(posedge clk_i) sda_low_o <= !b;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    r = sda_i;
    scl_o <= 1'b0;
endtask
task automatic start();
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
endtask
task automatic stop();
    @(posedge clk_i) sda_low_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
endtask
task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
endtask
task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
        bit_x(1'b1, r);
        b[i] = r;
    end
    bit_x(last, r);
endtask
endmodule // gxp_i2c_master

// ### testbench/gxp_expander_tb.sv
`timescale 1ns/10ps
module gxp_expander_tb;
localparam logic [31:0] DEFS = 32'hFF00FF5A;
logic       clk_i = 1'b0;
logic       rst_n_i = 1'b0;
logic [2:0] asel = 3'h5;
logic [7:0] ext = 8'h00;
logic [7:0] rd_v;
logic       ack;
int         failures = 0;
int         compares = 0;
wire        scl, m_low, sda_o, sda_oe, int_n, int_oe, sda_w;
wire [7:0]  pin_o, pin_oe, pull;
assign sda_w = !(m_low || (sda_oe && !sda_o));
always #5 clk_i = ~clk_i;
gxp_i2c_master mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
gxp_expander dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(asel),
    .port_pin_i((pin_oe & pin_o) | (~pin_oe & ext)), .port_pin_o(pin_o),
    .port_pin_oe_o(pin_oe), .port_pullup_o(pull), .int_n_o(int_n), .int_oe_o(int_oe));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
        failures++;
        $display("Error %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic wr(input logic [2:0] a, input logic ea, input logic [7:0] c, input logic [7:0] d,
                  input logic dat);
    mst.start();
    mst.put({4'h4, a, 1'b0}, ack);
    chk("addr ack", {7'h0, ack}, {7'h0, ea});
    if (ea) mst.put(c, ack);
    if (ea && dat) mst.put(d, ack);
    chk("byte ack", {7'h0, ack}, {7'h0, ea});
    mst.stop();
endtask
task automatic rd(input logic [7:0] e);
    mst.start();
    mst.put({4'h4, asel, 1'b1}, ack);
    mst.get(1'b1, rd_v);
    mst.stop();
    chk("read", rd_v, e);
endtask
task automatic do_rst();
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("pullup", pull, 8'hFF);
    chk("drive", pin_oe, 8'h00);
    chk("latch", pin_o, 8'hFF);
endtask
task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
initial
begin
    do_rst();
    ext <= 8'h5A;
    for (int i = 0; i < 20 && int_oe !== 1'b1; i++) @(posedge clk_i);
    chk("int set", {7'h0, int_oe}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
        wr(asel, 1'b1, i[7:0], 8'h00, 1'b0);
        rd(DEFS[i*8 +: 8]);
        rd(DEFS[i*8 +: 8]);
    end
    chk("int clear", {7'h0, int_oe}, 8'h00);
    wr(asel, 1'b1, 8'h02, 8'h0F, 1'b1);
    wr(asel, 1'b1, 8'h00, 8'h00, 1'b0);
    rd(8'h55);
    wr(asel, 1'b1, 8'h01, 8'hA5, 1'b1);
    wr(asel, 1'b1, 8'h03, 8'h0F, 1'b1);
    repeat (2) @(posedge clk_i);
    chk("latch", pin_o, 8'hA5);
    chk("drive", pin_oe, 8'hF0);
    chk("pullup", pull, 8'h0F);
    rd(8'h0F);
    asel <= 3'h2;
    repeat (4) @(posedge clk_i);
    wr(3'h5, 1'b0, 8'h01, 8'h00, 1'b1);
    wr(3'h2, 1'b1, 8'h01, 8'h3C, 1'b1);
    repeat (2) @(posedge clk_i);
    chk("latch", pin_o, 8'h3C);
    ext <= 8'h00;
    do_rst();
    ext <= 8'h0F;
    rd(8'h0F);
    test_done();
end
endmodule // gxp_expander_tb
